// ### hdl/nsrh_top.sv
// Two-channel requantizer front path: registers, buffers and half-band filters.
// Assumes samples and register accesses are synchronous to clk_i.
`timescale 1ns/1ps
module nsrh_top #(
  parameter bit LOW_SPEED_GRADE = 1'b0
) (
  // Clock and reset.
  input  wire logic                                               clk_i,
  input  wire logic                                               sys_rst_i,
  // Register port.
  input  wire logic                                               reg_wr_i,
  input  wire logic                                               reg_rd_i,
  input  wire logic [nsrh_pkg::NCH-1:0]                           reg_chan_i,
  input  wire logic [nsrh_pkg::ADDR_W-1:0]                        reg_addr_i,
  input  wire logic [7:0]                                         reg_wdata_i,
  output logic [7:0]                                              reg_rdata_o,
  output logic                                                    reg_rvalid_o,
  // Converter samples.
  input  wire logic [nsrh_pkg::NCH-1:0]                           adc_valid_i,
  output logic [nsrh_pkg::NCH-1:0]                                adc_ready_o,
  input  wire logic [nsrh_pkg::NCH-1:0][nsrh_pkg::SAMPLE_W-1:0]   adc_data_i,
  // Filtered samples.
  output logic [nsrh_pkg::NCH-1:0]                                smp_valid_o,
  input  wire logic [nsrh_pkg::NCH-1:0]                           smp_ready_i,
  output logic [nsrh_pkg::NCH-1:0][nsrh_pkg::SAMPLE_W-1:0]        smp_data_o,
  // Band status.
  output logic [nsrh_pkg::NCH-1:0]                                nsr_active_o,
  output logic [nsrh_pkg::NCH-1:0][nsrh_pkg::EDGE_W-1:0]          left_band_edge_o,
  output logic [nsrh_pkg::NCH-1:0][nsrh_pkg::EDGE_W-1:0]          band_centre_o,
  output logic [nsrh_pkg::NCH-1:0][nsrh_pkg::EDGE_W-1:0]          right_band_edge_o
);
  import nsrh_pkg::*;

  nsrh_top_s                     st;
  nsrh_top_s                     nxt;
  logic                          rd_ch;
  logic [NCH-1:0]                en;
  logic [NCH-1:0]                p28;
  logic [NCH-1:0][TW_W-1:0]      tw_max;
  logic [NCH-1:0]                bypass;
  logic [NCH-1:0]                hp;
  logic [NCH-1:0]                atten;
  logic [NCH-1:0]                buf_valid;
  logic [NCH-1:0]                buf_ready;
  logic [NCH-1:0][SAMPLE_W-1:0]  buf_data;
  logic [NCH-1:0][SAMPLE_W-1:0]  hbf_data;

  // Reads return the lowest selected channel.
  assign rd_ch = ~reg_chan_i[0];

  always_comb begin
    nxt        = st;
    nxt.rvalid = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (reg_wr_i && reg_chan_i[c]) begin
        case (reg_addr_i)
          HALFBAND_MODE_CONTROL_OFS: begin
            nxt.hb_ctl[c] = reg_wdata_i & HB_CTL_MASK;
          end
          REQUANTIZER_MODE_SELECT_OFS: begin
            nxt.mode_sel[c] = reg_wdata_i & MODE_SEL_MASK;
            if (reg_wdata_i[MODE_LSB +: MODE_W] == MODE_BW28 &&
                st.tune[c][TW_W-1:0] > TW_MAX_BW28) begin
              nxt.tune[c] = {2'h0, TW_MAX_BW28};
            end
          end
          REQUANTIZER_BAND_TUNING_OFS: begin
            if (reg_wdata_i[TW_W-1:0] <= tw_max[c]) begin
              nxt.tune[c] = reg_wdata_i & TUNE_MASK;
            end
          end
          default: begin
          end
        endcase
      end
      nxt.active[c] = en[c];
      nxt.left[c]   = {1'b0, st.tune[c][TW_W-1:0]};
      nxt.centre[c] = {1'b0, st.tune[c][TW_W-1:0]} +
                      (p28[c] ? CENTRE_OFS_BW28 : CENTRE_OFS_BW21);
      nxt.right[c]  = {1'b0, st.tune[c][TW_W-1:0]} +
                      (p28[c] ? WIDTH_BW28 : WIDTH_BW21);
    end
    if (reg_rd_i) begin
      nxt.rvalid = 1'b1;
      case (reg_addr_i)
        HALFBAND_MODE_CONTROL_OFS: begin
          nxt.rdata = st.hb_ctl[rd_ch];
        end
        REQUANTIZER_MODE_SELECT_OFS: begin
          nxt.rdata = st.mode_sel[rd_ch];
        end
        REQUANTIZER_BAND_TUNING_OFS: begin
          nxt.rdata = st.tune[rd_ch];
        end
        default: begin
          nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= TOP_RST;
    end else begin
      st <= nxt;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign en[c]     = st.mode_sel[c][NSR_EN_BIT];
    assign p28[c]    = st.mode_sel[c][MODE_LSB +: MODE_W] == MODE_BW28;
    assign tw_max[c] = p28[c] ? TW_MAX_BW28 : TW_MAX_BW21;
    assign bypass[c] = !en[c] || (LOW_SPEED_GRADE && !st.hb_ctl[c][HB_EN_BIT]);
    assign hp[c]     = en[c] && st.hb_ctl[c][HB_HP_BIT];
    assign atten[c]  = en[c];

    nsrh_skid u_buf (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (adc_valid_i[c]),
      .in_ready_o  (adc_ready_o[c]),
      .in_data_i   (adc_data_i[c]),
      .out_valid_o (buf_valid[c]),
      .out_ready_i (buf_ready[c]),
      .out_data_o  (buf_data[c])
    );

    nsrh_halfband u_hbf (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .bypass_i    (bypass[c]),
      .hp_mode_i   (hp[c]),
      .atten_i     (atten[c]),
      .in_valid_i  (buf_valid[c]),
      .in_ready_o  (buf_ready[c]),
      .in_data_i   (buf_data[c]),
      .out_valid_o (smp_valid_o[c]),
      .out_ready_i (smp_ready_i[c]),
      .out_data_o  (hbf_data[c])
    );

    assign smp_data_o[c] = hbf_data[c];

    a_hbf_forced: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !LOW_SPEED_GRADE && en[c] |-> !bypass[c])
      else $error("half-band bypassed while requantizer on");
    a_hp_follow: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_chan_i[c] && reg_addr_i == HALFBAND_MODE_CONTROL_OFS && en[c]
      |=> hp[c] == $past(reg_wdata_i[HB_HP_BIT]))
      else $error("filter mode does not follow register");
    a_tune_range: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st.tune[c][TW_W-1:0] <= (p28[c] ? TW_MAX_BW28 : TW_MAX_BW21))
      else $error("tuning word outside profile range");
    a_band_21: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st.mode_sel[c][MODE_LSB +: MODE_W] == MODE_BW21
      |=> st.right[c] - st.left[c] == WIDTH_BW21 &&
          st.centre[c] - st.left[c] == CENTRE_OFS_BW21)
      else $error("21 percent band edges wrong");
    a_band_28: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st.mode_sel[c][MODE_LSB +: MODE_W] == MODE_BW28
      |=> st.right[c] - st.left[c] == WIDTH_BW28 &&
          st.centre[c] - st.left[c] == CENTRE_OFS_BW28)
      else $error("28 percent band edges wrong");
    a_hb_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_chan_i[c] && reg_addr_i == HALFBAND_MODE_CONTROL_OFS
      |=> st.hb_ctl[c] == ($past(reg_wdata_i) & HB_CTL_MASK))
      else $error("half-band mode write not stored");
    a_mode_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_chan_i[c] && reg_addr_i == REQUANTIZER_MODE_SELECT_OFS
      |=> st.mode_sel[c] == ($past(reg_wdata_i) & MODE_SEL_MASK))
      else $error("profile write not stored");
    a_tune_keep: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_chan_i[c] && reg_addr_i == REQUANTIZER_BAND_TUNING_OFS &&
      reg_wdata_i[TW_W-1:0] > tw_max[c]
      |=> st.tune[c] == $past(st.tune[c]))
      else $error("out-of-range tuning word stored");
    a_band_nyquist: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st.right[c] <= TW_MAX_BW21 + WIDTH_BW21)
      else $error("right band edge beyond range");
  end

  assign reg_rdata_o       = st.rdata;
  assign reg_rvalid_o      = st.rvalid;
  assign nsr_active_o      = st.active;
  assign left_band_edge_o  = st.left;
  assign band_centre_o     = st.centre;
  assign right_band_edge_o = st.right;

  a_reset_enable: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> (&en) && (&st.active))
    else $error("requantizer not enabled after reset");
  a_chan_sep: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    reg_wr_i && reg_chan_i == 2'h1
    |=> st.tune[1] == $past(st.tune[1]) && st.mode_sel[1] == $past(st.mode_sel[1]) &&
        st.hb_ctl[1] == $past(st.hb_ctl[1]))
    else $error("write leaked into other channel");
  a_rvalid_pulse: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after request");
  a_rd_unmapped: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i != HALFBAND_MODE_CONTROL_OFS &&
    reg_addr_i != REQUANTIZER_MODE_SELECT_OFS && reg_addr_i != REQUANTIZER_BAND_TUNING_OFS
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ### hdl/nsrh_pkg.sv
// Constants, register map and state types of the requantizer path.
// Assumes one clock and a synchronous active-high reset in every user.
package nsrh_pkg;
  localparam int SAMPLE_W   = 14;
  localparam int ACC_W      = 27;
  localparam int PROD_W     = 37;
  localparam int NCH        = 2;
  localparam int NTAP       = 19;
  localparam int NPAIR      = 5;
  localparam int CENTRE_IDX = 9;
  localparam int ADDR_W     = 12;
  localparam int EDGE_W     = 7;
  localparam int TW_W       = 6;
  localparam int MODE_W     = 3;
  localparam int MODE_LSB   = 1;
  localparam int NSR_EN_BIT = 0;
  localparam int HB_EN_BIT  = 0;
  localparam int HB_HP_BIT  = 7;
  localparam int OUT_SHIFT  = 19;

  localparam logic [ADDR_W-1:0] HALFBAND_MODE_CONTROL_OFS   = 12'h41e;
  localparam logic [ADDR_W-1:0] REQUANTIZER_MODE_SELECT_OFS = 12'h420;
  localparam logic [ADDR_W-1:0] REQUANTIZER_BAND_TUNING_OFS = 12'h422;

  localparam logic [7:0] HB_CTL_MASK   = 8'h81;
  localparam logic [7:0] MODE_SEL_MASK = 8'h0f;
  localparam logic [7:0] TUNE_MASK     = 8'h3f;
  localparam logic [7:0] HB_CTL_RST    = 8'h00;
  localparam logic [7:0] MODE_SEL_RST  = 8'h01;
  localparam logic [7:0] TUNE_RST      = 8'h00;

  localparam logic [MODE_W-1:0] MODE_BW21 = 3'h0;
  localparam logic [MODE_W-1:0] MODE_BW28 = 3'h1;

  // Band figures count steps of 0.5 % of the converter sample rate.
  localparam logic [TW_W-1:0]   TW_MAX_BW21     = 6'h3a;
  localparam logic [TW_W-1:0]   TW_MAX_BW28     = 6'h2b;
  localparam logic [EDGE_W-1:0] CENTRE_OFS_BW21 = 7'h15;
  localparam logic [EDGE_W-1:0] CENTRE_OFS_BW28 = 7'h1c;
  localparam logic [EDGE_W-1:0] WIDTH_BW21      = 7'h2a;
  localparam logic [EDGE_W-1:0] WIDTH_BW28      = 7'h38;

  // Pair k weighs taps 2k and 18-2k.
  localparam logic [NPAIR-1:0][11:0] HB_PAIR_COEF =
    {12'h284, 12'hf3e, 12'h05d, 12'hfd1, 12'h019};
  localparam logic signed [11:0]       HB_CENTRE_COEF = 12'h400;
  localparam logic signed [12:0]       HB_UNITY       = 13'h0800;
  localparam logic signed [ACC_W-1:0]  HB_DC_LP       = 27'h000_0812;
  localparam logic signed [ACC_W-1:0]  HB_DC_HP       = 27'h000_0012;
  localparam logic signed [9:0]        GAIN_ATTEN     = 10'h0b5;
  localparam logic signed [9:0]        GAIN_UNITY     = 10'h100;
  localparam logic signed [PROD_W-1:0] ROUND_BIAS     = 37'h00_0004_0000;
  localparam logic signed [PROD_W-1:0] PROD_SAT_MAX   = 37'h00_0000_1fff;
  localparam logic signed [PROD_W-1:0] PROD_SAT_MIN   = 37'h1f_ffff_e000;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX   = 14'h1fff;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN   = 14'h2000;
  localparam logic signed [ACC_W-1:0]  ACC_HALF       = 27'h100_0000;
  localparam logic signed [SAMPLE_W-1:0] OUT_HALF_ATTEN = 14'h16a0;

  typedef struct packed {
    logic [SAMPLE_W-1:0] e0;
    logic [SAMPLE_W-1:0] e1;
    logic [1:0]          cnt;
    logic                rdy;
  } nsrh_skid_s;

  typedef struct packed {
    logic [NTAP-1:0][SAMPLE_W-1:0] taps;
    logic                          ph;
    logic                          s1v;
    logic signed [ACC_W-1:0]       acc;
    logic                          s2v;
    logic signed [SAMPLE_W-1:0]    smp;
  } nsrh_hbf_s;

  typedef struct packed {
    logic [NCH-1:0][7:0]        hb_ctl;
    logic [NCH-1:0][7:0]        mode_sel;
    logic [NCH-1:0][7:0]        tune;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [NCH-1:0]             active;
    logic [NCH-1:0][EDGE_W-1:0] left;
    logic [NCH-1:0][EDGE_W-1:0] centre;
    logic [NCH-1:0][EDGE_W-1:0] right;
  } nsrh_top_s;

  localparam nsrh_skid_s SKID_RST = '{e0: '0, e1: '0, cnt: 2'h0, rdy: 1'b1};
  localparam nsrh_hbf_s  HBF_RST  = '0;
  localparam nsrh_top_s  TOP_RST  = '{
    hb_ctl: {NCH{HB_CTL_RST}}, mode_sel: {NCH{MODE_SEL_RST}},
    tune: {NCH{TUNE_RST}}, rdata: 8'h00, rvalid: 1'b0, active: {NCH{1'b1}},
    left: '0, centre: {NCH{CENTRE_OFS_BW21}}, right: {NCH{WIDTH_BW21}}};
endpackage

// ### hdl/nsrh_skid.sv
// Two-entry sample buffer with valid and ready on both sides.
// Assumes the source holds its word while ready is low.
`timescale 1ns/1ps
module nsrh_skid (
  // Clock and reset.
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  // Filling side.
  input  wire logic                         in_valid_i,
  output logic                              in_ready_o,
  input  wire logic [nsrh_pkg::SAMPLE_W-1:0] in_data_i,
  // Draining side.
  output logic                              out_valid_o,
  input  wire logic                         out_ready_i,
  output logic [nsrh_pkg::SAMPLE_W-1:0]     out_data_o
);
  import nsrh_pkg::*;

  nsrh_skid_s st;
  nsrh_skid_s nxt;
  logic       push;
  logic       pop;

  always_comb begin
    nxt  = st;
    push = in_valid_i && st.rdy;
    pop  = (st.cnt != 2'h0) && out_ready_i;
    case ({push, pop})
      2'b10: begin
        if (st.cnt == 2'h0) begin
          nxt.e0 = in_data_i;
        end else begin
          nxt.e1 = in_data_i;
        end
        nxt.cnt = st.cnt + 2'h1;
      end
      2'b01: begin
        nxt.e0  = st.e1;
        nxt.cnt = st.cnt - 2'h1;
      end
      2'b11: begin
        if (st.cnt == 2'h1) begin
          nxt.e0 = in_data_i;
        end else begin
          nxt.e0 = st.e1;
          nxt.e1 = in_data_i;
        end
      end
      default: begin
      end
    endcase
    nxt.rdy = nxt.cnt != 2'h2;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= SKID_RST;
    end else begin
      st <= nxt;
    end
  end

  assign in_ready_o  = st.rdy;
  assign out_valid_o = st.cnt != 2'h0;
  assign out_data_o  = st.e0;
endmodule

// ### hdl/nsrh_halfband.sv
// Decimate-by-two half-band filter with output gain, rounding and saturation.
// Assumes the buffer ahead of it holds samples while this stage stalls.
`timescale 1ns/1ps
module nsrh_halfband (
  // Clock and reset.
  input  wire logic                                clk_i,
  input  wire logic                                sys_rst_i,
  // Configuration.
  input  wire logic                                bypass_i,
  input  wire logic                                hp_mode_i,
  input  wire logic                                atten_i,
  // Sample input.
  input  wire logic                                in_valid_i,
  output logic                                     in_ready_o,
  input  wire logic signed [nsrh_pkg::SAMPLE_W-1:0] in_data_i,
  // Sample output.
  output logic                                     out_valid_o,
  input  wire logic                                out_ready_i,
  output logic signed [nsrh_pkg::SAMPLE_W-1:0]     out_data_o
);
  import nsrh_pkg::*;

  nsrh_hbf_s                     st;
  nsrh_hbf_s                     nxt;
  logic [NTAP-1:0][SAMPLE_W-1:0] nt;
  logic signed [ACC_W-1:0]       pair_prod [NPAIR];
  logic signed [ACC_W-1:0]       centre_prod;
  logic signed [ACC_W-1:0]       acc_v;
  logic signed [PROD_W-1:0]      prod_v;
  logic signed [PROD_W-1:0]      rnd_v;
  logic                          adv;
  logic                          take;

  // The newest sample sits at index zero.
  assign nt = {st.taps[NTAP-2:0], in_data_i};

  for (genvar k = 0; k < NPAIR; k++) begin : g_pair
    assign pair_prod[k] = ACC_W'($signed(HB_PAIR_COEF[k])) *
                          (ACC_W'($signed(nt[2*k])) + ACC_W'($signed(nt[NTAP-1-2*k])));
  end
  assign centre_prod = ACC_W'(HB_CENTRE_COEF) * ACC_W'($signed(nt[CENTRE_IDX]));

  always_comb begin
    nxt    = st;
    acc_v  = centre_prod;
    prod_v = '0;
    rnd_v  = '0;
    adv    = !st.s2v || out_ready_i;
    take   = in_valid_i && adv;
    if (hp_mode_i) begin
      acc_v = -centre_prod;
    end
    for (int k = 0; k < NPAIR; k++) begin
      acc_v = acc_v + pair_prod[k];
    end
    if (adv) begin
      nxt.s2v = st.s1v;
      nxt.s1v = 1'b0;
      if (st.s1v) begin
        prod_v = PROD_W'(st.acc) * PROD_W'(atten_i ? GAIN_ATTEN : GAIN_UNITY);
        rnd_v  = (prod_v + ROUND_BIAS) >>> OUT_SHIFT;
        if (rnd_v > PROD_SAT_MAX) begin
          nxt.smp = SAMPLE_MAX;
        end else if (rnd_v < PROD_SAT_MIN) begin
          nxt.smp = SAMPLE_MIN;
        end else begin
          nxt.smp = rnd_v[SAMPLE_W-1:0];
        end
      end
      if (take) begin
        nxt.taps = nt;
        if (bypass_i) begin
          nxt.ph  = 1'b0;
          nxt.s1v = 1'b1;
          nxt.acc = ACC_W'($signed(in_data_i)) * ACC_W'(HB_UNITY);
        end else begin
          nxt.ph  = ~st.ph;
          nxt.s1v = st.ph;
          nxt.acc = st.ph ? acc_v : st.acc;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= HBF_RST;
    end else begin
      st <= nxt;
    end
  end

  assign in_ready_o  = adv;
  assign out_valid_o = st.s2v;
  assign out_data_o  = st.smp;

  a_decim_skip: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && !bypass_i && !st.ph |=> !st.s1v && st.ph)
    else $error("half-band emitted on an even input");
  a_decim_emit: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && !bypass_i && st.ph |=> st.s1v && !st.ph ##1 st.s2v)
    else $error("half-band missed an output");
  a_lp_dc_sum: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && !bypass_i && st.ph && !hp_mode_i &&
    (st.taps[NTAP-2:0] == {(NTAP-1){in_data_i}})
    |=> st.acc == ACC_W'($signed($past(in_data_i))) * HB_DC_LP)
    else $error("low-pass tap sum wrong");
  a_hp_dc_sum: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && !bypass_i && st.ph && hp_mode_i &&
    (st.taps[NTAP-2:0] == {(NTAP-1){in_data_i}})
    |=> st.acc == ACC_W'($signed($past(in_data_i))) * HB_DC_HP)
    else $error("high-pass centre tap not negated");
  a_atten_gain: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    adv && st.s1v && atten_i && st.acc >= ACC_HALF &&
    st.acc <= ACC_HALF + (ACC_HALF >>> 2)
    |=> st.smp >= OUT_HALF_ATTEN && st.smp < SAMPLE_MAX)
    else $error("attenuation gain wrong");
  a_out_sat: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    adv && st.s1v && !atten_i && st.acc >= ACC_HALF - ACC_W'(HB_UNITY)
    |=> st.smp == SAMPLE_MAX)
    else $error("output not saturated");
endmodule

// ### verif/nsrh_src.sv
// Behavioural converter sample source for one channel.
// Assumes ready comes from a register of the block.
`timescale 1ns/1ps
module nsrh_src (
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  // Control from the bench.
  input  wire logic                          start_i,
  input  wire logic                          rnd_i,
  input  wire logic [7:0]                    num_i,
  input  wire logic [nsrh_pkg::SAMPLE_W-1:0] level_i,
  // Sample stream.
  input  wire logic                          ready_i,
  output logic                               valid_o,
  output logic [nsrh_pkg::SAMPLE_W-1:0]      data_o
);
  int left;
  // Words hold until taken; idle data toggles.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
      data_o <= '0;
      left = 0;
    end else begin
      if (valid_o && ready_i)
        left = left - 1;
      if (start_i)
        left = num_i;
      if (!valid_o || ready_i) begin
        if (left > 0 && $urandom_range(0, 3) != 0) begin
          valid_o <= 1'b1;
          data_o <= (rnd_i && $urandom_range(0, 7) != 0) ? 14'($urandom) : level_i;
        end else begin
          valid_o <= 1'b0;
          data_o <= ~data_o;
        end
      end
    end
  end
endmodule

// ### verif/nsrh_top_tb.sv
// Self-checking bench of the two-channel requantizer path.
// Assumes the fast grade and the sample source model beside it.
`timescale 1ns/1ps
module nsrh_top_tb;
  import nsrh_pkg::*;
  localparam int LP_SUM = 2 * (25 - 47 + 93 - 194 + 644) + 1024;
  logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [NCH-1:0] reg_chan_i, adc_ready_o, smp_valid_o, smp_ready_i, nsr_active_o, go, rnd;
  wire logic [NCH-1:0] adc_valid_i;
  wire logic [NCH-1:0][SAMPLE_W-1:0] adc_data_i;
  logic [NCH-1:0][SAMPLE_W-1:0] smp_data_o, lvl;
  logic [NCH-1:0][EDGE_W-1:0] left_band_edge_o, band_centre_o, right_band_edge_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, num;
  logic [SAMPLE_W-1:0] iq[NCH][$], oq[NCH][$];
  logic [SAMPLE_W-1:0] v;
  int errors, num_checks, cyc;

  nsrh_top uut (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_chan_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .adc_valid_i, .adc_ready_o, .adc_data_i,
    .smp_valid_o, .smp_ready_i, .smp_data_o, .nsr_active_o, .left_band_edge_o,
    .band_centre_o, .right_band_edge_o);
  for (genvar c = 0; c < NCH; c++) begin : g_src
    nsrh_src src (.clk_i, .sys_rst_i, .start_i(go[c]), .rnd_i(rnd[c]), .num_i(num),
      .level_i(lvl[c]), .ready_i(adc_ready_o[c]), .valid_o(adc_valid_i[c]),
      .data_o(adc_data_i[c]));
  end

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    smp_ready_i <= 2'($urandom);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
    if (!sys_rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        if (adc_valid_i[c] && adc_ready_o[c])
          iq[c].push_back(adc_data_i[c]);
        if (smp_valid_o[c] && smp_ready_i[c])
          oq[c].push_back(smp_data_o[c]);
      end
    end
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk14(input string n, input logic [13:0] e, input logic [13:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_chan_i <= ch;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_chan_i <= ch;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk8("rvalid", 8'h01, {7'h00, reg_rvalid_o});
    chk8("rdata", e, reg_rdata_o);
  endtask
  task automatic band(input int c, input int l, input int w);
    chk8("left", 8'(l), {1'b0, left_band_edge_o[c]});
    chk8("centre", 8'(l + w / 2), {1'b0, band_centre_o[c]});
    chk8("right", 8'(l + w), {1'b0, right_band_edge_o[c]});
  endtask
  task automatic send(input logic [1:0] r, input int e0, input int e1);
    for (int c = 0; c < NCH; c++) begin
      iq[c] = {};
      oq[c] = {};
    end
    @(posedge clk_i);
    go <= 2'b11;
    rnd <= r;
    @(posedge clk_i);
    go <= 2'b00;
    while (oq[0].size() < e0 || oq[1].size() < e1)
      @(posedge clk_i);
    repeat (6) @(posedge clk_i);
    chk8("count0", 8'(e0), 8'(oq[0].size()));
    chk8("count1", 8'(e1), 8'(oq[1].size()));
  endtask
  function automatic logic [13:0] dc_exp(input logic [13:0] x, input int s);
    longint p;
    p = (longint'($signed(x)) * s * 181 + 64'sd262144) >>> 19;
    if (p > 8191)
      p = 8191;
    if (p < -8192)
      p = -8192;
    return p[13:0];
  endfunction
  function automatic int fir_acc(input int c, input int n);
    int h[10] = '{25, 0, -47, 0, 93, 0, -194, 0, 644, 1024};
    int a;
    a = 0;
    for (int i = 0; i < NTAP; i++)
      a += h[(i < 10) ? i : 18 - i] * int'($signed(iq[c][n - i]));
    return a;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    void'($urandom(53));
    {reg_wr_i, reg_rd_i, reg_chan_i, reg_addr_i, reg_wdata_i} = '0;
    {go, rnd, lvl, num} = '0;
    sys_rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk8("active", 8'h03, {6'h00, nsr_active_o});
    band(0, 0, 42);
    rd(2'b01, REQUANTIZER_MODE_SELECT_OFS, 8'h01);
    rd(2'b01, 12'h400, 8'h00);
    wr(2'b01, HALFBAND_MODE_CONTROL_OFS, 8'hff);
    rd(2'b01, HALFBAND_MODE_CONTROL_OFS, 8'h81);
    wr(2'b01, REQUANTIZER_BAND_TUNING_OFS, 8'd58);
    band(0, 58, 42);
    wr(2'b01, REQUANTIZER_BAND_TUNING_OFS, 8'd59);
    rd(2'b01, REQUANTIZER_BAND_TUNING_OFS, 8'd58);
    band(1, 0, 42);
    wr(2'b01, REQUANTIZER_MODE_SELECT_OFS, 8'h03);
    band(0, 43, 56);
    wr(2'b01, REQUANTIZER_BAND_TUNING_OFS, 8'd44);
    rd(2'b01, REQUANTIZER_BAND_TUNING_OFS, 8'd43);
    wr(2'b01, REQUANTIZER_MODE_SELECT_OFS, 8'h01);
    num <= 8'd40;
    for (int k = 0; k < 3; k++) begin
      v = (k == 2) ? 14'h1fff : 14'($urandom);
      lvl <= {v, v};
      wr(2'b11, HALFBAND_MODE_CONTROL_OFS, (k == 1) ? 8'h80 : 8'h00);
      send(2'b00, 20, 20);
      for (int c = 0; c < NCH; c++)
        for (int j = 10; j < 20; j++)
          chk14("dc", dc_exp(v, (k == 1) ? LP_SUM - 2048 : LP_SUM), oq[c][j]);
    end
    wr(2'b10, REQUANTIZER_MODE_SELECT_OFS, 8'h00);
    chk8("active", 8'h01, {6'h00, nsr_active_o});
    num <= 8'd40;
    send(2'b11, 20, 40);
    for (int j = 9; j < 20; j++)
      chk14("fir", dc_exp(14'h0001, fir_acc(0, 2 * j + 1)), oq[0][j]);
    for (int j = 0; j < 40; j++)
      chk14("bypass", iq[1][j], oq[1][j]);
    report_and_stop();
  end
endmodule
